// ===== hw/dvr_top.sv
/*
 * Digital volume ramp controller with an AHB-Lite register slave.
 * Assumes fs_tick is a one-cycle pulse per sample period from logic on hclk;
 * soft_mute_pin_n, clock_error and power_fail are asynchronous pins.
 */
// Contract
// R1 - Normal down rate: 00 every period, 01 every two, 11 mutes instantly.
// R2 - Soft mute from pin or control register uses normal down settings.
// R3 - Normal down step: 00 is 4 dB, 01 is 2 dB, 10 is 1 dB.
// R4 - Normal up rate: 1, 2 or 4 periods; 11 restores instantly.
// R5 - Normal up step: 4, 2, 1 or 0.5 dB per update.
// R6 - Soft unmute from pin or control register uses normal up settings.
// R7 - Emergency down rate: 1, 2 or 4 periods; 11 mutes instantly.
// R8 - Emergency down step: 4, 2, 1 or 0.5 dB per update.
// R9 - Clock error or power outage ramps down with emergency settings.
// R10 - Volume code is linear 0.5 dB steps; all ones is mute, default 0 dB.
// R11 - Auto-mute link clear mutes channels independently, set only both together.
// R12 - Ramping stops at the target, never overshooting on a partial step.
// R13 - Interval counter restarts at each update; both channels share settings.
`timescale 1ns/1ps
module dvr_top
    import dvr_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Audio side inputs.
    input wire logic fs_tick,
    input wire logic soft_mute_pin_n,
    input wire logic clock_error,
    input wire logic power_fail,
    input wire logic zero_left,
    input wire logic zero_right,
    // Applied volume and auto-mute state.
    output logic [7:0] vol_left,
    output logic [7:0] vol_right,
    output logic auto_mute_left,
    output logic auto_mute_right
);

    // ========================================================================
    // State of the module.
    // ========================================================================
    typedef struct packed {
        logic [7:0] soft_mute;
        logic [7:0] vol_set_left;
        logic [7:0] vol_set_right;
        logic [7:0] normal;
        logic [7:0] emerg;
        logic [7:0] auto;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_idx;
        logic [31:0] rdata;
        logic readyout;
        logic resp;
        logic [2:0] cnt;
        logic update;
        logic [1:0] amute;
    } dvr_top_s;

    localparam dvr_top_s RST_STATE = '{
        soft_mute: RST_SOFT_MUTE,
        vol_set_left: RST_VOL,
        vol_set_right: RST_VOL,
        normal: RST_NORMAL,
        emerg: RST_EMERG,
        auto: RST_AUTO,
        sync1: 3'h0,
        sync2: 3'h0,
        dp_valid: 1'b0,
        dp_write: 1'b0,
        dp_idx: 8'h00,
        rdata: 32'h0000_0000,
        readyout: 1'b1,
        resp: 1'b0,
        cnt: 3'h0,
        update: 1'b0,
        amute: 2'h0
    };

    dvr_top_s q;
    dvr_top_s d;
    dvr_ramp_if rif ();

    logic emergency;
    logic soft_mute_req;
    logic [1:0] down_rate;
    logic [1:0] down_step;
    logic [1:0] up_rate;
    logic [1:0] up_step;
    logic [1:0] mute_ch;
    logic any_down;
    logic [2:0] periods;
    logic zl;
    logic zr;

    // ========================================================================
    // Mute requests and settings selection.
    // ========================================================================
    // Pin is active low; it is inverted before the synchroniser, so sync2 is high on request.
    assign emergency = q.sync2[1] | q.sync2[2];
    assign soft_mute_req = q.sync2[0] | q.soft_mute[F_SOFT_MUTE]; // [R2] [R6]
    assign mute_ch[0] = emergency | soft_mute_req | q.amute[0];
    assign mute_ch[1] = emergency | soft_mute_req | q.amute[1];

    // Emergency settings replace the normal ramp-down ones while a fault is seen.
    assign down_rate = emergency ? q.emerg[F_DOWN_RATE +: 2] : q.normal[F_DOWN_RATE +: 2]; // [R9] [R1] [R7]
    assign down_step = emergency ? q.emerg[F_DOWN_STEP +: 2] : q.normal[F_DOWN_STEP +: 2]; // [R9] [R3] [R8]
    assign up_rate = q.normal[F_UP_RATE +: 2]; // [R4]
    assign up_step = q.normal[F_UP_STEP +: 2]; // [R5]

    // Targets: mute is the all-ones code, otherwise the software set volume.
    assign rif.target[7:0] = mute_ch[0] ? VOL_MUTE : q.vol_set_left; // [R10]
    assign rif.target[15:8] = mute_ch[1] ? VOL_MUTE : q.vol_set_right; // [R10]

    // One set of ramp settings drives both channel steppers.
    assign rif.update = q.update; // [R13]
    assign rif.step_down = dvr_step_units(down_step);
    assign rif.step_up = dvr_step_units(up_step);
    assign rif.instant_down = (down_rate == RATE_INSTANT);
    assign rif.instant_up = (up_rate == RATE_INSTANT);

    // The interval follows the down rate whenever any channel is still heading down.
    assign any_down = (rif.target[7:0] > rif.level[7:0]) | (rif.target[15:8] > rif.level[15:8]);
    assign periods = any_down ? dvr_rate_periods(down_rate) : dvr_rate_periods(up_rate);

    // Auto-mute requests gated by their enables.
    assign zl = q.auto[F_EN_FIRST] & zero_left;
    assign zr = q.auto[F_EN_SECOND] & zero_right;

    // ========================================================================
    // Channel steppers.
    // ========================================================================
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        dvr_ramp_chan #(
            .CH(ch)
        ) u_chan (
            .hclk(hclk),
            .hresetn(hresetn),
            .rif(rif)
        );
    end

    // ========================================================================
    // Next state: bus slave, synchronisers, interval counter, auto-mute.
    // ========================================================================
    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        d = q;
        d.readyout = 1'b1;
        d.resp = 1'b0;
        d.update = 1'b0;

        // Two-flop synchronisers for the asynchronous pins.
        d.sync1 = {power_fail, clock_error, ~soft_mute_pin_n};
        d.sync2 = q.sync1;

        // Data phase of a write: store into the addressed register, reserved bits read zero.
        if (q.dp_valid && q.dp_write) begin
            unique case (q.dp_idx)
                IDX_SOFT_MUTE: d.soft_mute = hwdata[7:0] & MASK_SOFT_MUTE;
                IDX_VOL_LEFT: d.vol_set_left = hwdata[7:0];
                IDX_VOL_RIGHT: d.vol_set_right = hwdata[7:0];
                IDX_NORMAL: d.normal = hwdata[7:0];
                IDX_EMERG: d.emerg = hwdata[7:0] & MASK_EMERG;
                IDX_AUTO: d.auto = hwdata[7:0] & MASK_AUTO;
                default: d.dp_idx = q.dp_idx;
            endcase
        end

        // Read mux over the updated registers, so a write then a read sees new data.
        unique case (haddr[ADDR_IDX_HI:ADDR_IDX_LO])
            IDX_SOFT_MUTE: rd = {24'h00_0000, d.soft_mute};
            IDX_VOL_LEFT: rd = {24'h00_0000, d.vol_set_left};
            IDX_VOL_RIGHT: rd = {24'h00_0000, d.vol_set_right};
            IDX_NORMAL: rd = {24'h00_0000, d.normal};
            IDX_EMERG: rd = {24'h00_0000, d.emerg};
            IDX_AUTO: rd = {24'h00_0000, d.auto};
            IDX_STATUS: rd = {12'h000, q.amute, soft_mute_req, emergency, rif.level};
            default: rd = 32'h0000_0000;
        endcase

        // Address phase: zero wait states, so every selected transfer is taken.
        d.dp_valid = hsel & hready & htrans[1];
        d.dp_write = hwrite;
        d.dp_idx = haddr[ADDR_IDX_HI:ADDR_IDX_LO];
        if (hsel && hready && htrans[1] && !hwrite) begin
            d.rdata = rd;
        end

        // Sample period counter, restarted at each update.
        if (fs_tick) begin
            if (q.cnt + 3'h1 >= periods) begin
                d.cnt = 3'h0; // [R13]
                d.update = 1'b1;
            end else begin
                d.cnt = q.cnt + 3'h1;
            end
        end

        // Linked auto-mute only fires when both channels qualify.
        if (d.auto[F_LINK]) begin
            d.amute = {2{zl & zr}}; // [R11]
        end else begin
            d.amute = {zr, zl}; // [R11]
        end
    end

    // Registers the module state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs, all from flip-flops.
    // ========================================================================
    assign hreadyout = q.readyout;
    assign hresp = q.resp;
    assign hrdata = q.rdata;
    assign vol_left = rif.level[7:0];
    assign vol_right = rif.level[15:8];
    assign auto_mute_left = q.amute[0];
    assign auto_mute_right = q.amute[1];

    // ========================================================================
    // Checks.
    // ========================================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_NORMAL_INSTANT_MUTE: assert property ( // [R1]
        !emergency && q.normal[F_DOWN_RATE +: 2] == 2'h3 && mute_ch[0] |=> vol_left == 8'hff
    ) else $error("normal instant mute did not reach mute");
    AST_SOFT_MUTE_TARGET: assert property ( // [R2]
        q.soft_mute[F_SOFT_MUTE] && !emergency |-> rif.target == 16'hffff &&
        rif.step_down == dvr_step_units(q.normal[F_DOWN_STEP +: 2])
    ) else $error("soft mute did not select normal ramp down");
    AST_UNMUTE_TARGET: assert property ( // [R6]
        !soft_mute_req && !emergency && !q.amute[0] |-> rif.target[7:0] == q.vol_set_left &&
        rif.step_up == dvr_step_units(q.normal[F_UP_STEP +: 2])
    ) else $error("unmute did not target set volume");
    AST_UP_INSTANT: assert property ( // [R4]
        !any_down && q.normal[F_UP_RATE +: 2] == 2'h3 && !mute_ch[0] && $stable(q.vol_set_left)
        |=> vol_left == $past(q.vol_set_left)
    ) else $error("instant unmute did not restore volume");
    AST_EMERG_INSTANT_MUTE: assert property ( // [R7]
        emergency && q.emerg[F_DOWN_RATE +: 2] == 2'h3 |=> vol_left == 8'hff && vol_right == 8'hff
    ) else $error("emergency instant mute failed");
    AST_EMERG_SETTINGS: assert property ( // [R9]
        $rose(q.sync2[1]) |-> rif.target == 16'hffff &&
        rif.step_down == dvr_step_units(q.emerg[F_DOWN_STEP +: 2])
    ) else $error("clock error did not select emergency ramp");
    AST_LINKED_AUTO_MUTE: assert property ( // [R11]
        q.auto[F_LINK] |-> q.amute[0] == q.amute[1]
    ) else $error("linked auto mute split channels");
    AST_COUNTER_RESTART: assert property ( // [R13]
        q.update |-> q.cnt == 3'h0 ##1 !q.update
    ) else $error("interval counter not restarted at update");
    AST_MUTE_CODE: assert property ( // [R10]
        mute_ch[1] && rif.instant_down |=> vol_right == 8'hff
    ) else $error("mute code is not all ones");
    AST_BUS_OKAY: assert property (
        hreadyout && !hresp
    ) else $error("slave response not OKAY");

endmodule // dvr_top

// ===== shared/dvr_pkg.sv
/*
 * Constants for the digital volume ramp controller: register indices, field
 * positions, reset values and the decode of rate and step codes.
 * Assumes registers sit on a 32-bit bus, one word each, byte address = 4 x index.
 */
package dvr_pkg;

    // ========================================================================
    // Register indices (byte address is four times the index).
    // ========================================================================
    localparam logic [7:0] IDX_SOFT_MUTE = 8'h03;
    localparam logic [7:0] IDX_VOL_LEFT = 8'h3d;
    localparam logic [7:0] IDX_VOL_RIGHT = 8'h3e;
    localparam logic [7:0] IDX_NORMAL = 8'h3f;
    localparam logic [7:0] IDX_EMERG = 8'h40;
    localparam logic [7:0] IDX_AUTO = 8'h41;
    localparam logic [7:0] IDX_STATUS = 8'h50;
    localparam int ADDR_IDX_LO = 2;
    localparam int ADDR_IDX_HI = 9;

    // ========================================================================
    // Reset values and writable masks.
    // ========================================================================
    localparam logic [7:0] RST_SOFT_MUTE = 8'h00;
    localparam logic [7:0] RST_VOL = 8'h30;
    localparam logic [7:0] RST_NORMAL = 8'h33;
    localparam logic [7:0] RST_EMERG = 8'h10;
    localparam logic [7:0] RST_AUTO = 8'h07;
    localparam logic [7:0] MASK_SOFT_MUTE = 8'h01;
    localparam logic [7:0] MASK_EMERG = 8'hf0;
    localparam logic [7:0] MASK_AUTO = 8'h07;
    localparam logic [7:0] VOL_MUTE = 8'hff;

    // ========================================================================
    // Field positions.
    // ========================================================================
    localparam int F_DOWN_RATE = 6;
    localparam int F_DOWN_STEP = 4;
    localparam int F_UP_RATE = 2;
    localparam int F_UP_STEP = 0;
    localparam int F_LINK = 2;
    localparam int F_EN_FIRST = 1;
    localparam int F_EN_SECOND = 0;
    localparam int F_SOFT_MUTE = 0;
    localparam logic [1:0] RATE_INSTANT = 2'h3;

    // Step code to volume code units of 0.5 dB.
    function automatic logic [7:0] dvr_step_units(input logic [1:0] code);
        unique case (code)
            2'h0: dvr_step_units = 8'h08;
            2'h1: dvr_step_units = 8'h04;
            2'h2: dvr_step_units = 8'h02;
            2'h3: dvr_step_units = 8'h01;
        endcase
    endfunction

    // Rate code to sample periods between updates; the instant code maps to four, like 10.
    function automatic logic [2:0] dvr_rate_periods(input logic [1:0] code);
        unique case (code)
            2'h0: dvr_rate_periods = 3'h1;
            2'h1: dvr_rate_periods = 3'h2;
            default: dvr_rate_periods = 3'h4;
        endcase
    endfunction

endpackage

// ===== shared/dvr_ramp_if.sv
/*
 * Carrier between the ramp controller and its per-channel steppers.
 * Assumes one clock; the controller drives settings, each stepper its level slice.
 */
`timescale 1ns/1ps
interface dvr_ramp_if;
    logic update;
    logic [7:0] step_down;
    logic [7:0] step_up;
    logic instant_down;
    logic instant_up;
    logic [15:0] target;
    wire [15:0] level;

    // ========================================================================
    // Ports of each party.
    // ========================================================================
    modport ctrl (
        output update, step_down, step_up, instant_down, instant_up, target,
        input level
    );
    modport chan (
        input update, step_down, step_up, instant_down, instant_up, target,
        output level
    );
endinterface

// ===== hw/dvr_ramp_chan.sv
/*
 * One channel stepper: moves the applied volume code toward its target.
 * Assumes update pulses and step sizes come from the shared controller.
 */
`timescale 1ns/1ps
module dvr_ramp_chan
    import dvr_pkg::*;
#(
    parameter int CH = 0
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Shared ramp settings.
    dvr_ramp_if.chan rif
);

    typedef struct packed {
        logic [7:0] level;
    } dvr_chan_s;

    dvr_chan_s st_q;
    dvr_chan_s st_d;
    logic [7:0] tgt;

    assign tgt = rif.target[CH*8 +: 8];
    assign rif.level[CH*8 +: 8] = st_q.level;

    // ========================================================================
    // Step logic: larger code is quieter, so ramping down raises the code.
    // ========================================================================
    always_comb begin
        st_d = st_q;
        if (tgt > st_q.level) begin
            if (rif.instant_down) begin
                st_d.level = tgt; // [R1] [R7]
            end else if (rif.update) begin
                st_d.level = ((tgt - st_q.level) <= rif.step_down) ? tgt : st_q.level + rif.step_down; // [R12]
            end
        end else if (tgt < st_q.level) begin
            if (rif.instant_up) begin
                st_d.level = tgt; // [R4]
            end else if (rif.update) begin
                st_d.level = ((st_q.level - tgt) <= rif.step_up) ? tgt : st_q.level - rif.step_up; // [R12]
            end
        end
    end

    // Registers the channel state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{level: RST_VOL};
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_DOWN_STEP: assert property ( // [R3]
        rif.update && !rif.instant_down && tgt > st_q.level && (tgt - st_q.level) > rif.step_down
        |=> st_q.level == $past(st_q.level) + $past(rif.step_down)
    ) else $error("down step size wrong");
    AST_UP_STEP: assert property ( // [R5]
        rif.update && !rif.instant_up && tgt < st_q.level && (st_q.level - tgt) > rif.step_up
        |=> st_q.level == $past(st_q.level) - $past(rif.step_up)
    ) else $error("up step size wrong");
    AST_NO_OVERSHOOT: assert property ( // [R12]
        $stable(tgt) && st_q.level <= tgt |=> st_q.level <= $past(tgt)
    ) else $error("volume overshot target");

endmodule // dvr_ramp_chan

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the volume ramp controller: register access over AHB-Lite,
 * soft mute ramps from register and pin, emergency ramps and auto-mute.
 * Assumes the slave answers without wait states and returns registered read data.
 */
`timescale 1ns/1ps
module tb_top;
    import dvr_pkg::*;

    // ========================================================================
    // Signals, notes and counters.
    // ========================================================================
    typedef struct {logic [7:0] val; int ticks;} dvr_tb_note_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic fs_tick = 1'b0;
    logic soft_mute_pin_n = 1'b1;
    logic clock_error = 1'b0;
    logic power_fail = 1'b0;
    logic zero_left = 1'b0;
    logic zero_right = 1'b0;
    logic [7:0] vol_left;
    logic [7:0] vol_right;
    logic auto_mute_left;
    logic auto_mute_right;
    wire [7:0] vol [2];
    dvr_tb_note_s vq [2][$];
    logic [31:0] rq [$];
    logic [31:0] rd_val;
    event rd_ev;
    logic [7:0] cur [2] = '{8'h30, 8'h30};
    logic [7:0] pos [2] = '{8'h30, 8'h30};
    logic [7:0] setv [2] = '{8'h30, 8'h30};
    int tick_cnt [2] = '{0, 0};
    logic mon_on = 1'b0;
    int failures = 0;
    int num_checks = 0;

    assign vol[0] = vol_left;
    assign vol[1] = vol_right;

    // Clock of 4 ns.
    initial begin
        forever #2 hclk = ~hclk;
    end

    dvr_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .fs_tick(fs_tick), .soft_mute_pin_n(soft_mute_pin_n),
        .clock_error(clock_error), .power_fail(power_fail), .zero_left(zero_left),
        .zero_right(zero_right), .vol_left(vol_left), .vol_right(vol_right),
        .auto_mute_left(auto_mute_left), .auto_mute_right(auto_mute_right));

    // ========================================================================
    // Compare tasks and the closing report.
    // ========================================================================
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s is %b", $time, what, got);
        end
    endtask

    // A zero tick count in a note means the spacing is not checked.
    task automatic check_vol(input int c, input logic [7:0] got, input int t);
        dvr_tb_note_s n;
        num_checks++;
        if (vq[c].size() == 0) begin
            failures++;
            $display("wrong value at %0t: channel %0d moved to %h unasked", $time, c, got);
        end else begin
            n = vq[c].pop_front();
            if (got !== n.val || (n.ticks != 0 && t != n.ticks)) begin
                failures++;
                $display("wrong value at %0t: channel %0d %h after %0d ticks, expected %h", $time, c, got, t, n.val);
            end
        end
    endtask

    // ========================================================================
    // Bus master: address phase held until hready, then data phase until hready.
    // ========================================================================
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd_val = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, idx, 32'h0);
        ->rd_ev;
    endtask

    // Read results are compared with the oldest expected value taken off rq as they arrive.
    always @(rd_ev) begin
        check_reg(rd_val, rq.pop_front());
    end

    // ========================================================================
    // Volume expectations: every step toward the target, clamped at it.
    // ========================================================================
    task automatic plan(input int c, input logic [7:0] to, input logic [1:0] sc, input logic [1:0] rc);
        int v;
        int u;
        int t;
        v = pos[c];
        u = 8 >> sc;
        t = 0;
        while (v != to) begin
            if (rc == 2'h3) v = to;
            else if (to > v) v = (v + u > to) ? to : v + u;
            else v = (v < to + u) ? to : v - u;
            vq[c].push_back('{8'(v), t});
            t = 1 << rc;
        end
        pos[c] = to;
    endtask

    task automatic plan_all(input logic mute, input logic [1:0] sc, input logic [1:0] rc);
        for (int c = 0; c < 2; c++) plan(c, mute ? 8'hff : setv[c], sc, rc);
    endtask

    // Sample-period pulses every five cycles until all expected steps were seen.
    task automatic ramp();
        int n;
        n = 0;
        while (vq[0].size() + vq[1].size() > 0 && n < 4000) begin
            @(posedge hclk);
            fs_tick <= 1'b1;
            @(posedge hclk);
            fs_tick <= 1'b0;
            repeat (3) @(posedge hclk);
            n++;
        end
        if (vq[0].size() + vq[1].size() > 0) begin
            failures++;
            summarize();
        end
    endtask

    // Each change of an applied volume is compared with the oldest note.
    always @(posedge hclk) begin
        if (hresetn && mon_on) begin
            for (int c = 0; c < 2; c++) begin
                if (fs_tick === 1'b1) tick_cnt[c]++;
                if (vol[c] !== cur[c]) begin
                    check_vol(c, vol[c], tick_cnt[c]);
                    cur[c] = vol[c];
                    tick_cnt[c] = 0;
                end
            end
        end
    end

    // ========================================================================
    // Main sequence.
    // ========================================================================
    initial begin
        void'($urandom(91));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        mon_on = 1'b1;
        rd(IDX_NORMAL, 32'h33);
        rd(IDX_EMERG, 32'h10);
        rd(IDX_AUTO, 32'h07);
        rd(IDX_STATUS, 32'h3030);
        rd(8'h7f, 32'h0);
        wr(IDX_EMERG, 8'hff);
        rd(IDX_EMERG, 32'hf0);
        $display("test registers done");
        // Soft mute from the register with down step codes 00, 01 and 10, then back up.
        for (int d = 0; d < 3; d++) begin
            wr(IDX_NORMAL, {2'h0, 2'(d), 2'h0, 2'(d)});
            plan_all(1'b1, 2'(d), 2'h0);
            wr(IDX_SOFT_MUTE, 8'h01);
            ramp();
            for (int c = 0; c < 2; c++) begin
                setv[c] = 8'($urandom_range(254, 0));
                wr(8'(IDX_VOL_LEFT + c), setv[c]);
                rd(8'(IDX_VOL_LEFT + c), {24'h0, setv[c]});
            end
            plan_all(1'b0, 2'(d), 2'h0);
            wr(IDX_SOFT_MUTE, 8'h00);
            ramp();
        end
        $display("test register soft mute done");
        // Pin request: down every two periods by 2 dB, up every four by 0.5 dB.
        wr(IDX_NORMAL, 8'h5b);
        plan_all(1'b1, 2'h1, 2'h1);
        @(posedge hclk);
        soft_mute_pin_n <= 1'b0;
        ramp();
        plan_all(1'b0, 2'h3, 2'h2);
        @(posedge hclk);
        soft_mute_pin_n <= 1'b1;
        ramp();
        $display("test pin soft mute done");
        // Instant mute and instant unmute need no sample period at all.
        wr(IDX_NORMAL, 8'hc2);
        plan_all(1'b1, 2'h0, 2'h3);
        wr(IDX_SOFT_MUTE, 8'h01);
        repeat (6) @(posedge hclk);
        check_flag(vq[0].size() + vq[1].size() == 0, 1'b1, "instant mute");
        wr(IDX_NORMAL, 8'h0c);
        plan_all(1'b0, 2'h0, 2'h3);
        wr(IDX_SOFT_MUTE, 8'h00);
        repeat (6) @(posedge hclk);
        check_flag(vq[0].size() + vq[1].size() == 0, 1'b1, "instant unmute");
        $display("test instant done");
        // Faults ramp down with the emergency settings, which differ from the normal ones.
        for (int r = 0; r < 4; r++) begin
            wr(IDX_NORMAL, {4'h0, 2'(r), 2'(r)});
            wr(IDX_EMERG, {2'(r), ~2'(r), 4'h0});
            plan_all(1'b1, ~2'(r), 2'(r));
            @(posedge hclk);
            if (r % 2 == 1) power_fail <= 1'b1;
            else clock_error <= 1'b1;
            ramp();
            plan_all(1'b0, 2'(r), 2'(r));
            @(posedge hclk);
            power_fail <= 1'b0;
            clock_error <= 1'b0;
            ramp();
        end
        $display("test emergency done");
        // Auto-mute linked and independent; no sample pulses, so volumes stay put.
        wr(IDX_NORMAL, 8'h00);
        wr(IDX_AUTO, 8'h07);
        @(posedge hclk);
        zero_left <= 1'b1;
        repeat (4) @(posedge hclk);
        check_flag(auto_mute_left, 1'b0, "linked left alone");
        @(posedge hclk);
        zero_right <= 1'b1;
        repeat (4) @(posedge hclk);
        check_flag(auto_mute_left & auto_mute_right, 1'b1, "linked both");
        wr(IDX_AUTO, 8'h03);
        @(posedge hclk);
        zero_right <= 1'b0;
        repeat (4) @(posedge hclk);
        check_flag(auto_mute_left, 1'b1, "independent left");
        check_flag(auto_mute_right, 1'b0, "independent right");
        @(posedge hclk);
        zero_left <= 1'b0;
        repeat (4) @(posedge hclk);
        check_flag(auto_mute_left, 1'b0, "left released");
        $display("test auto mute done");
        repeat (10) @(posedge hclk);
        summarize();
    end
endmodule // tb_top
